// file: dv/spdsel_host_model.sv
// Host controller model: drives segment select terminals and analog channel 1
`timescale 1ns/100ps
module spdsel_host_model (
	input wire logic i_clk,
	input wire logic [2:0] i_code,
	input wire logic signed [15:0] i_mv,
	output logic o_bit0 = 1'b0,
	output logic o_bit1 = 1'b0,
	output logic o_bit2 = 1'b0,
	output logic o_valid = 1'b0,
	output logic signed [15:0] o_mv = 16'sh0000
);
	// Terminals assigned to the three select functions, held as levels
	always_ff @(posedge i_clk) begin
		o_bit0 <= i_code[0];
		o_bit1 <= i_code[1];
		o_bit2 <= i_code[2];
		o_mv <= i_mv;
		o_valid <= ~o_valid;
	end
endmodule : spdsel_host_model

// file: dv/speed_command_select_tb.sv
// Self-checking bench for the speed command selector
`timescale 1ns/100ps
module speed_command_select_tb;
	import spdsel_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, running = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, seed = 32'h50D5;
	logic err;
	logic [2:0] code = 3'h0;
	logic signed [15:0] mv = 16'sh0, lim = 16'sh0, mv_s, spd [8];
	logic b0, b1, b2, vld;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic signed [15:0] cmd, lim_o;
	logic [2:0] seg;
	int fails = 0, tests_run = 0, n;
	int tab [5][5] = '{'{0, 0, 20, 1000, 500}, '{200, 0, 20, 1000, 400}, '{0, 100, 20, 1000, 450},
		'{0, 0, 20, 8, 0}, '{0, 0, 20, -1000, -500}};
	initial forever #12.5 clk = ~clk;
	spdsel_host_model spdsel_host_model_inst (.i_clk(clk), .i_code(code), .i_mv(mv), .o_bit0(b0), .o_bit1(b1),
		.o_bit2(b2), .o_valid(vld), .o_mv(mv_s));
	spdsel_top spdsel_top_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .I_SEGMENT_SELECT_BIT0(b0), .I_SEGMENT_SELECT_BIT1(b1), .I_SEGMENT_SELECT_BIT2(b2),
		.I_DRIVE_RUNNING(running), .I_ANALOG_SPEED_VALID(vld), .I_ANALOG_SPEED_CHANNEL(mv_s),
		.I_ANALOG_LIMIT_CHANNEL(lim), .O_SPEED_CMD(cmd), .O_SEGMENT_INDEX(seg), .O_SPEED_LIMIT_MV(lim_o));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return (s >> 1) ^ (s[0] ? 32'hA3000000 : 32'h0);
	endfunction : lfsr
	function automatic int exp_rpm(input int b, input int dr, input int dz, input int v);
		int c;
		c = v - dr - b;
		if ((c < 0 ? -c : c) * 2 <= dz) return 0;
		c = (c * 512) >>> 10;
		return c > 5000 ? 5000 : (c < -5000 ? -5000 : c);
	endfunction : exp_rpm
	function automatic logic [31:0] sx(input int v);
		return 32'(v);
	endfunction : sx
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// Setup cycle, access phase held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (k >= 20) begin fails++; print_verdict(); end
	endtask : apb
	task automatic wait_cmd(input logic [15:0] exp);
		n = 0;
		while (cmd !== exp && n < 3000) begin @(posedge clk); n++; end
		if (n >= 3000) begin fails++; print_verdict(); end
	endtask : wait_cmd
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, all stored speeds included
		apb(1'b0, ADDR_SRC_SEL, 32'h0); check(rd, 32'(RST_SRC));
		for (int i = 0; i < NSEG; i++) begin apb(1'b0, 8'(ADDR_SPEED_BASE + 4 * i), 32'h0); check(rd, 32'h0); end
		apb(1'b0, ADDR_FILTER_TC, 32'h0); check(rd, 32'(RST_TC));
		apb(1'b0, ADDR_DEAD_ZONE, 32'h0); check(rd, 32'(RST_DZ));
		apb(1'b0, ADDR_ZERO_DRIFT, 32'h0); check(rd, 32'h0);
		apb(1'b0, ADDR_BIAS, 32'h0); check(rd, 32'(RST_BIAS));
		apb(1'b0, 8'h40, 32'h0); check(32'(err), 32'h1); // Unmapped address refused
		$display("test reset_values done");
		// Random table, end values included; each code selects its own entry
		for (int i = 0; i < NSEG; i++) begin
			seed = lfsr(seed);
			spd[i] = (i == 0) ? -16'sd5000 : (i == 7) ? 16'sd5000 : 16'(int'(seed % 10001) - 5000);
			apb(1'b1, 8'(ADDR_SPEED_BASE + 4 * i), sx(spd[i]));
			apb(1'b0, 8'(ADDR_SPEED_BASE + 4 * i), 32'h0); check(rd, sx(spd[i]));
		end
		for (int c = 7; c >= 0; c--) begin
			code <= 3'(c);
			repeat (8) @(posedge clk);
			check(32'(seg), 32'(c));
			check(sx(cmd), sx(spd[c]));
		end
		apb(1'b1, ADDR_SPEED_BASE, sx(6000)); apb(1'b0, ADDR_SPEED_BASE, 32'h0); check(rd, sx(5000));
		repeat (8) @(posedge clk);
		check(sx(cmd), sx(5000));
		$display("test segment_table done");
		// Source change refused while running
		running <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b1, ADDR_SRC_SEL, 32'h1); apb(1'b0, ADDR_SRC_SEL, 32'h0); check(rd, 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0); check(32'(rd[7]), 32'h1);
		running <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b1, ADDR_SRC_SEL, 32'h1); apb(1'b0, ADDR_SRC_SEL, 32'h0); check(rd, 32'h1);
		$display("test source_select done");
		// Analog chain: drift, bias, dead zone, scale with filter bypassed
		apb(1'b1, ADDR_FILTER_TC, 32'h0);
		for (int r = 0; r < 5; r++) begin
			apb(1'b1, ADDR_BIAS, sx(tab[r][0]));
			apb(1'b1, ADDR_ZERO_DRIFT, sx(tab[r][1]));
			apb(1'b1, ADDR_DEAD_ZONE, sx(tab[r][2]));
			mv <= 16'(tab[r][3]);
			seed = lfsr(seed);
			lim <= 16'(seed);
			wait_cmd(16'(exp_rpm(tab[r][0], tab[r][1], tab[r][2], tab[r][3])));
			repeat (4) @(posedge clk);
			check(sx(cmd), sx(exp_rpm(tab[r][0], tab[r][1], tab[r][2], tab[r][3])));
			check(32'(lim_o), 32'(lim));
		end
		// First-order filter: output moves gradually toward the target
		apb(1'b1, ADDR_FILTER_TC, 32'h0000_0064);
		mv <= 16'sd4000;
		repeat (1200) @(posedge clk);
		check(32'(cmd > -16'sd500 && cmd < 16'sd2000), 32'h1);
		apb(1'b1, ADDR_FILTER_TC, 32'h0000_0001);
		wait_cmd(16'sd2000);
		check(sx(cmd), sx(2000));
		// Calibration captures the sample; a large one is clamped
		mv <= 16'sd300;
		repeat (8) @(posedge clk);
		apb(1'b1, ADDR_CALIB, 32'h1);
		repeat (8) @(posedge clk);
		apb(1'b0, ADDR_ZERO_DRIFT, 32'h0); check(rd, sx(300));
		mv <= 16'sd700;
		repeat (8) @(posedge clk);
		apb(1'b1, ADDR_CALIB, 32'h1);
		repeat (8) @(posedge clk);
		apb(1'b0, ADDR_ZERO_DRIFT, 32'h0); check(rd, sx(500));
		apb(1'b0, ADDR_STATUS, 32'h0); check(32'(rd[5]), 32'h0);
		wait_cmd(16'(exp_rpm(0, 500, 20, 700)));
		apb(1'b0, ADDR_SPEED_OUT, 32'h0); check(rd, sx(exp_rpm(0, 500, 20, 700)));
		$display("test analog_chain done");
		// Reset in mid-run returns source select and zero drift to their defaults, and the command to 0
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, ADDR_SRC_SEL, 32'h0); check(rd, 32'(RST_SRC));
		apb(1'b0, ADDR_ZERO_DRIFT, 32'h0); check(rd, 32'(RST_DRIFT));
		repeat (8) @(posedge clk);
		check(sx(cmd), sx(0));
		$display("test mid_reset done");
		print_verdict();
	end
endmodule : speed_command_select_tb

// file: rtl/spdsel_pkg.sv
// Package: register map, field widths, reset values and timing for the speed command selector
package spdsel_pkg;
	localparam int DW = 16;
	localparam logic [7:0] ADDR_SRC_SEL = 8'h00;
	localparam logic [7:0] ADDR_SPEED_BASE = 8'h04;
	localparam logic [7:0] ADDR_BIAS = 8'h24;
	localparam logic [7:0] ADDR_FILTER_TC = 8'h28;
	localparam logic [7:0] ADDR_DEAD_ZONE = 8'h2C;
	localparam logic [7:0] ADDR_ZERO_DRIFT = 8'h30;
	localparam logic [7:0] ADDR_STATUS = 8'h34;
	localparam logic [7:0] ADDR_CALIB = 8'h38;
	localparam logic [7:0] ADDR_SPEED_OUT = 8'h3C;
	localparam int NSEG = 8;
	localparam int SEG_W = 3;
	localparam logic signed [DW-1:0] SPEED_MIN = -16'sd5000;
	localparam logic signed [DW-1:0] SPEED_MAX = 16'sd5000;
	localparam logic signed [DW-1:0] DRIFT_MIN = -16'sd500;
	localparam logic signed [DW-1:0] DRIFT_MAX = 16'sd500;
	localparam logic signed [DW-1:0] BIAS_MIN = -16'sd5000;
	localparam logic signed [DW-1:0] BIAS_MAX = 16'sd5000;
	localparam logic [DW-1:0] DZ_MAX = 16'h03E8;
	localparam logic [DW-1:0] TC_MAX = 16'hEA60;
	localparam logic [DW-1:0] RST_SRC = 16'h0000;
	localparam logic [DW-1:0] RST_SPEED = 16'h0000;
	localparam logic [DW-1:0] RST_BIAS = 16'h0000;
	localparam logic [DW-1:0] RST_TC = 16'h00C8;
	localparam logic [DW-1:0] RST_DZ = 16'h0014;
	localparam logic [DW-1:0] RST_DRIFT = 16'h0000;
	// Filter tick: time constant unit 0.01 ms at 40 MHz
	localparam int CLK_HZ = 40000000;
	localparam int TC_UNIT_NS = 10000;
	localparam int TICK_CYC = (TC_UNIT_NS * (CLK_HZ / 1000000)) / 1000;
	localparam logic [8:0] TICK_LAST = 9'(TICK_CYC - 1);
	// Analog scale: rpm = mV * SCALE_NUM >> SCALE_SHIFT
	localparam logic signed [DW-1:0] SCALE_NUM = 16'sh0200;
	localparam int SCALE_SHIFT = 10;
	localparam int ACC_FRAC = 16;
endpackage : spdsel_pkg

// file: rtl/spdsel_top.sv
// Speed command selector: stored segment table or conditioned analog channel 1
`timescale 1ns/100ps
module spdsel_top
	import spdsel_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_SEGMENT_SELECT_BIT0,
	input wire logic I_SEGMENT_SELECT_BIT1,
	input wire logic I_SEGMENT_SELECT_BIT2,
	input wire logic I_DRIVE_RUNNING,
	input wire logic I_ANALOG_SPEED_VALID,
	input wire logic signed [DW-1:0] I_ANALOG_SPEED_CHANNEL,
	input wire logic signed [DW-1:0] I_ANALOG_LIMIT_CHANNEL,
	output logic signed [DW-1:0] O_SPEED_CMD,
	output logic [SEG_W-1:0] O_SEGMENT_INDEX,
	output logic signed [DW-1:0] O_SPEED_LIMIT_MV
);
	typedef enum logic {SPDSEL_IDLE, SPDSEL_ACCESS} spdsel_state_t;
	spdsel_state_t bus_q;
	logic [SEG_W-1:0] sel_m_q, sel_s_q;
	logic run_m_q, run_s_q;
	logic src_q;
	logic signed [DW-1:0] speed_q [NSEG];
	logic signed [DW-1:0] bias_q, drift_q, limit_m_q, limit_s_q;
	logic [DW-1:0] tc_q, dz_q;
	logic cal_req_q, src_rej_q;
	logic signed [DW-1:0] ai_m_q, ai_s_q;
	logic av_m_q, av_s_q;
	logic [8:0] tick_q;
	logic signed [DW+ACC_FRAC+1:0] acc_q;
	logic signed [DW-1:0] speed_out_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;

	wire acc_now = I_PSEL && I_PENABLE && bus_q == SPDSEL_ACCESS;
	// Writes land on the edge that completes the transfer, never on the first access edge
	wire wr_now = I_PSEL && I_PENABLE && pready_q && I_PWRITE;
	wire signed [DW-1:0] wdat = I_PWDATA[DW-1:0];
	wire [7:0] seg_off = I_PADDR - ADDR_SPEED_BASE;
	wire is_seg = I_PADDR >= ADDR_SPEED_BASE && I_PADDR < ADDR_BIAS && I_PADDR[1:0] == 2'h0;
	wire [SEG_W-1:0] seg_wi = seg_off[SEG_W+1:2];
	wire mapped = is_seg || I_PADDR == ADDR_SRC_SEL || I_PADDR == ADDR_BIAS || I_PADDR == ADDR_FILTER_TC
		|| I_PADDR == ADDR_DEAD_ZONE || I_PADDR == ADDR_ZERO_DRIFT || I_PADDR == ADDR_STATUS
		|| I_PADDR == ADDR_CALIB || I_PADDR == ADDR_SPEED_OUT;

	// Clamp helper keeps writes inside documented ranges
	function automatic logic signed [DW-1:0] clampv(input logic signed [DW-1:0] v,
		input logic signed [DW-1:0] lo, input logic signed [DW-1:0] hi);
		clampv = v < lo ? lo : (v > hi ? hi : v);
	endfunction : clampv

	// Two-flop synchronisers for pins and the analog sample port
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			sel_m_q <= 3'h0;
			sel_s_q <= 3'h0;
			run_m_q <= 1'b0;
			run_s_q <= 1'b0;
			ai_m_q <= 16'sh0000;
			ai_s_q <= 16'sh0000;
			av_m_q <= 1'b0;
			av_s_q <= 1'b0;
			limit_m_q <= 16'sh0000;
			limit_s_q <= 16'sh0000;
		end else begin
			sel_m_q <= {I_SEGMENT_SELECT_BIT2, I_SEGMENT_SELECT_BIT1, I_SEGMENT_SELECT_BIT0};
			sel_s_q <= sel_m_q;
			run_m_q <= I_DRIVE_RUNNING;
			run_s_q <= run_m_q;
			ai_m_q <= I_ANALOG_SPEED_CHANNEL;
			ai_s_q <= ai_m_q;
			av_m_q <= I_ANALOG_SPEED_VALID;
			av_s_q <= av_m_q;
			limit_m_q <= I_ANALOG_LIMIT_CHANNEL;
			limit_s_q <= limit_m_q;
		end
	end

	// APB slave: access phase with one wait state, error on unmapped address
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			bus_q <= SPDSEL_IDLE;
		end else begin
			bus_q <= (I_PSEL && !acc_now) ? SPDSEL_ACCESS : SPDSEL_IDLE;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			src_q <= RST_SRC[0];
			bias_q <= RST_BIAS;
			tc_q <= RST_TC;
			dz_q <= RST_DZ;
			src_rej_q <= 1'b0;
		end else if (wr_now) begin
			if (I_PADDR == ADDR_SRC_SEL) begin
				if (!run_s_q) begin
					src_q <= wdat[0];
				end
				src_rej_q <= run_s_q;
			end
			if (I_PADDR == ADDR_BIAS) bias_q <= clampv(wdat, BIAS_MIN, BIAS_MAX);
			if (I_PADDR == ADDR_FILTER_TC) tc_q <= wdat > TC_MAX ? TC_MAX : wdat;
			if (I_PADDR == ADDR_DEAD_ZONE) dz_q <= wdat > DZ_MAX ? DZ_MAX : wdat;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NSEG; g++) begin : g_seg
			always_ff @(posedge I_CLK) begin
				if (!I_RST_N) begin
					speed_q[g] <= RST_SPEED;
				end else if (wr_now && is_seg && seg_wi == SEG_W'(g)) begin
					speed_q[g] <= clampv(wdat, SPEED_MIN, SPEED_MAX);
				end
			end

			entry_range_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
				speed_q[g] >= SPEED_MIN && speed_q[g] <= SPEED_MAX)
				else $error("stored speed out of range");
		end
	endgenerate

	// Auto calibration latches the raw sample taken with zero input
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			drift_q <= RST_DRIFT;
			cal_req_q <= 1'b0;
		end else if (wr_now && I_PADDR == ADDR_ZERO_DRIFT) begin
			drift_q <= clampv(wdat, DRIFT_MIN, DRIFT_MAX);
		end else if (wr_now && I_PADDR == ADDR_CALIB && wdat[0]) begin
			cal_req_q <= 1'b1;
		end else if (cal_req_q && av_s_q) begin
			drift_q <= clampv(ai_s_q, DRIFT_MIN, DRIFT_MAX);
			cal_req_q <= 1'b0;
		end
	end

	// Conditioning chain: drift, bias, symmetric dead zone, then filter
	wire signed [DW+1:0] corr = 18'(ai_s_q) - 18'(drift_q) - 18'(bias_q);
	wire signed [DW+1:0] half_dz = 18'({1'b0, dz_q} >> 1);
	wire in_dz = corr <= half_dz && corr >= -half_dz;
	wire signed [DW+1:0] cond = in_dz ? 18'sh0 : corr;
	wire signed [DW+ACC_FRAC+1:0] cond_x = 34'(cond) <<< ACC_FRAC;
	wire signed [DW+ACC_FRAC+1:0] diff = cond_x - acc_q;
	wire signed [DW+ACC_FRAC+1:0] step = tc_q == 16'h0000 ? diff : diff / $signed({1'b0, tc_q});
	// Rounded, so a settled filter reaches its input despite truncated steps
	wire signed [DW+ACC_FRAC+1:0] acc_rnd = acc_q + (34'sh1 <<< (ACC_FRAC - 1));
	wire signed [DW+1:0] filt = 18'(acc_rnd >>> ACC_FRAC);
	wire signed [DW+DW+1:0] scaled_w = 34'(filt) * 34'(SCALE_NUM);
	wire signed [DW+DW+1:0] scaled_s = scaled_w >>> SCALE_SHIFT;
	wire signed [DW-1:0] ana_rpm = scaled_s > 34'(SPEED_MAX) ? SPEED_MAX
		: (scaled_s < 34'(SPEED_MIN) ? SPEED_MIN : DW'(scaled_s));
	wire signed [DW-1:0] int_rpm = speed_q[sel_s_q];
	wire signed [DW-1:0] speed_d = src_q ? ana_rpm : int_rpm;

	// First-order low-pass: one update per 0.01 ms, step = error / tc
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			tick_q <= 9'h000;
			acc_q <= '0;
		end else begin
			tick_q <= tick_q == TICK_LAST ? 9'h000 : tick_q + 9'h001;
			if (tick_q == TICK_LAST) acc_q <= acc_q + step;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			speed_out_q <= 16'sh0000;
			O_SPEED_CMD <= 16'sh0000;
			O_SEGMENT_INDEX <= 3'h0;
			O_SPEED_LIMIT_MV <= 16'sh0000;
		end else begin
			speed_out_q <= speed_d;
			O_SPEED_CMD <= speed_d;
			O_SEGMENT_INDEX <= sel_s_q;
			O_SPEED_LIMIT_MV <= limit_s_q;
		end
	end

	// Read mux
	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h0000_0000;
		if (is_seg) rd_d = {{16{speed_q[seg_wi][DW-1]}}, speed_q[seg_wi]};
		if (I_PADDR == ADDR_SRC_SEL) rd_d = {31'h0, src_q};
		if (I_PADDR == ADDR_BIAS) rd_d = {{16{bias_q[DW-1]}}, bias_q};
		if (I_PADDR == ADDR_FILTER_TC) rd_d = {16'h0, tc_q};
		if (I_PADDR == ADDR_DEAD_ZONE) rd_d = {16'h0, dz_q};
		if (I_PADDR == ADDR_ZERO_DRIFT) rd_d = {{16{drift_q[DW-1]}}, drift_q};
		if (I_PADDR == ADDR_STATUS) rd_d = {24'h0, src_rej_q, run_s_q, cal_req_q, 2'h0, sel_s_q};
		if (I_PADDR == ADDR_CALIB) rd_d = {31'h0, cal_req_q};
		if (I_PADDR == ADDR_SPEED_OUT) rd_d = {{16{speed_out_q[DW-1]}}, speed_out_q};
	end

	// Ready and data registered: answer one cycle after the access phase starts
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= I_PSEL && I_PENABLE && !pready_q;
			pslverr_q <= I_PSEL && I_PENABLE && !pready_q && !mapped;
			prdata_q <= (I_PSEL && !I_PWRITE) ? rd_d : 32'h0000_0000;
		end
	end
	assign O_PREADY = pready_q;
	assign O_PSLVERR = pslverr_q;
	assign O_PRDATA = prdata_q;

	// Source may not change while running
	src_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		run_s_q && $past(run_s_q) |-> src_q == $past(src_q))
		else $error("source changed while running");

	sequence seg_steady;
		$stable(sel_s_q) && !src_q && $stable(src_q) ##1 !src_q && $stable(speed_q[sel_s_q]);
	endsequence
	seg_out_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		seg_steady |=> O_SPEED_CMD == $past(speed_q[sel_s_q]))
		else $error("speed output does not follow selected segment");

	speed_range_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		O_SPEED_CMD >= SPEED_MIN && O_SPEED_CMD <= SPEED_MAX)
		else $error("speed out of range");

	drift_range_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		drift_q >= DRIFT_MIN && drift_q <= DRIFT_MAX)
		else $error("drift out of range");

	dz_zero_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(corr <= 18'(dz_q >> 1) && -corr <= 18'(dz_q >> 1)) |-> cond_x == '0)
		else $error("dead zone not applied");

	idx_pin_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		$past(I_RST_N, 2) |-> sel_s_q == $past({I_SEGMENT_SELECT_BIT2, I_SEGMENT_SELECT_BIT1,
		I_SEGMENT_SELECT_BIT0}, 2))
		else $error("segment index order wrong");

	idx_msb_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		$past(I_RST_N, 3) |-> O_SEGMENT_INDEX[SEG_W-1] == $past(I_SEGMENT_SELECT_BIT2, 3))
		else $error("select input 3 is not the index msb");

	analog_src_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		src_q ##1 src_q |-> O_SPEED_CMD == $past(ana_rpm))
		else $error("analog source not routed");

	tc_range_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		tc_q <= TC_MAX && dz_q <= DZ_MAX)
		else $error("filter or dead zone setting out of range");

	// Bus handshake, built from its two phases
	sequence apb_setup;
		I_PSEL && !I_PENABLE;
	endsequence
	sequence apb_access;
		I_PSEL && I_PENABLE;
	endsequence

	apb_answer_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		apb_setup ##1 apb_access |=> O_PREADY)
		else $error("no ready after access phase");

	ready_pulse_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");

	slverr_ready_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		O_PSLVERR |-> O_PREADY)
		else $error("error without ready");

	// A write before ready would let a held request land twice
	early_write_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		apb_access and !O_PREADY |=> $stable(bias_q) && $stable(src_q) && $stable(tc_q))
		else $error("register written before ready");

	reset_out_a: assert property (@(posedge I_CLK)
		!I_RST_N |=> O_SPEED_CMD == 16'sh0000 && O_SEGMENT_INDEX == '0 && !O_PREADY)
		else $error("outputs not cleared by reset");

	src_reset_a: assert property (@(posedge I_CLK)
		!I_RST_N |=> src_q == RST_SRC[0] && tc_q == RST_TC && dz_q == RST_DZ)
		else $error("settings not at defaults after reset");

	seg_zero_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!src_q && sel_s_q == '0 |=> O_SPEED_CMD == $past(speed_q[0]))
		else $error("idle select does not give stored value 0");

	idx_out_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		O_SEGMENT_INDEX == $past(sel_s_q))
		else $error("segment index output stale");

	bias_range_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		bias_q >= BIAS_MIN && bias_q <= BIAS_MAX)
		else $error("bias out of range");

	bias_write_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		wr_now && I_PADDR == ADDR_BIAS && wdat >= BIAS_MIN && wdat <= BIAS_MAX |=> bias_q == $past(wdat))
		else $error("bias write lost");

	tc_write_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		wr_now && I_PADDR == ADDR_FILTER_TC && wdat <= TC_MAX |=> tc_q == $past(wdat))
		else $error("filter constant write lost");

	seg_clamp_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		wr_now && is_seg && wdat > SPEED_MAX |=> speed_q[$past(seg_wi)] == SPEED_MAX)
		else $error("stored speed not clamped");

	src_refuse_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		wr_now && I_PADDR == ADDR_SRC_SEL && run_s_q |=> src_rej_q && $stable(src_q))
		else $error("source write not refused while running");

	src_accept_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		wr_now && I_PADDR == ADDR_SRC_SEL && !run_s_q |=> !src_rej_q && src_q == $past(wdat[0]))
		else $error("source write not taken while stopped");

	cal_done_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		cal_req_q && av_s_q && !wr_now |=> !cal_req_q)
		else $error("calibration request not served");

	cal_value_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		cal_req_q && av_s_q && !wr_now && ai_s_q >= DRIFT_MIN && ai_s_q <= DRIFT_MAX
		|=> drift_q == $past(ai_s_q))
		else $error("calibration captured wrong sample");

	tick_range_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		tick_q <= TICK_LAST)
		else $error("filter tick counter out of range");

	// The filter state may only move once per time-constant unit
	acc_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		tick_q != TICK_LAST |=> $stable(acc_q))
		else $error("filter moved between ticks");

	bypass_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		tc_q == '0 && tick_q == TICK_LAST |=> filt == $past(cond))
		else $error("zero time constant does not bypass");

	limit_pass_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		O_SPEED_LIMIT_MV == $past(limit_s_q))
		else $error("speed limit channel not passed");
endmodule : spdsel_top
